// >>> tiered_translator_packet_logic_tb.sv
// Self-checking testbench of the tiered translator packet processor
`timescale 1ns/1ps
`default_nettype none

module tiered_translator_packet_logic_tb;
    import ttp_pkg::*;
    typedef struct packed {logic [7:0] d; logic [7:0] m; logic s;} ttp_exp_t;
    logic        ref_clk_i, rst_n_i, side_bit_i, enhanced_i, in_sop_i, in_valid_i;
    logic        out_ready_i, in_ready_o, out_sop_o, out_valid_o, frame_sync_o;
    logic        hold, slow;
    logic [2:0]  mode_i;
    logic [7:0]  cfg_tier_i, in_data_i, out_data_o;
    logic [15:0] cfg_offset_i, timing_word_o;
    logic [3:0]  rsv_in_i, rsv_bits_o, rsv_val;
    logic [9:0]  pkt_num_o, adp_pn;
    logic [31:0] lfsr_q;
    int          n_fail, tests_run, fs_cnt;
    ttp_exp_t    exp_q[$];
    ttp_exp_t    ex;

    ttp_core ttp_core_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .mode_i(mode_i),
        .cfg_tier_i(cfg_tier_i), .cfg_offset_i(cfg_offset_i), .side_bit_i(side_bit_i),
        .enhanced_i(enhanced_i), .rsv_in_i(rsv_in_i), .in_data_i(in_data_i),
        .in_sop_i(in_sop_i), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
        .out_data_o(out_data_o), .out_sop_o(out_sop_o), .out_valid_o(out_valid_o),
        .out_ready_i(out_ready_i), .frame_sync_o(frame_sync_o),
        .timing_word_o(timing_word_o), .pkt_num_o(pkt_num_o), .rsv_bits_o(rsv_bits_o));

    ttp_sink_model ttp_sink_model_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .hold_i(hold), .slow_i(slow), .rsv_val_i(rsv_val), .out_ready_o(out_ready_i),
        .rsv_o(rsv_in_i));

    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask

    task automatic send_byte(input logic [7:0] d, input logic s, input logic [7:0] e,
                             input logic [7:0] m);
        int w = 0;
        @(negedge ref_clk_i);
        in_data_i = d;
        in_sop_i = s;
        in_valid_i = 1'b1;
        exp_q.push_back('{d: e, m: m, s: s});
        do begin
            @(posedge ref_clk_i);
            w++;
        end while (in_ready_o !== 1'b1 && w < 300);
        if (w >= 300) begin
            n_fail++;
            $display("Error at %0t: input never accepted", $time);
        end
    endtask

    task automatic send_pkt(input logic [7:0] sy, input logic fl, input logic [12:0] pid,
                            input logic [7:0] tier, input logic [9:0] pn, input logic [15:0] tw);
        logic [7:0] b, e, m, acc;
        logic       tpk, blank;
        tpk = (pid == NTP_PID);
        blank = tpk && (tier > cfg_tier_i || tier > TIER_MAX);
        acc = 8'h00;
        for (int i = 0; i < 188; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            case (i)
                0: b = sy;
                1: b = {fl, 2'b00, pid[12:8]};
                2: b = pid[7:0];
                4: b = tier;
                5: b = {6'h00, pn[9:8]};
                6: b = pn[7:0];
                7: b = tw[15:8];
                8: b = tw[7:0];
                default: b = lfsr_q[7:0];
            endcase
            e = b;
            m = 8'hFF;
            if (mode_i == MODE_XLAT) begin
                if (i == 0) e = SYNC_BYTE;
                if (i == 1) e = {1'b0, b[6:0]};
            end else if (mode_i == MODE_ADAPT) begin
                if (i == 0 && adp_pn == PKT_NUM_ZERO) e = SYNC_INV;
                if (i == 1) e = {side_bit_i, b[6:0]};
                if (blank && i > 4) e = BLANK_BYTE;
                else if (tpk && i == 5) e = {6'h00, adp_pn[9:8]};
                else if (tpk && i == 6) e = adp_pn[7:0];
                else if (tpk && i == 7) e = cfg_offset_i[15:8];
                else if (tpk && i == 8) e = cfg_offset_i[7:0];
                else if (tpk && i == 9) e = acc;
                else if (tpk && i == 10) e = acc ^ tier;
                if (i >= 4 && i <= 8) acc = acc ^ e;
            end
            send_byte(b, i == 0, e, m);
        end
        if (mode_i == MODE_ADAPT) adp_pn = adp_pn + 10'h001;
        @(negedge ref_clk_i);
        in_valid_i = 1'b0;
    endtask

    task automatic drain();
        int w = 0;
        while (exp_q.size() != 0 && w < 3000) begin
            @(posedge ref_clk_i);
            w++;
        end
        repeat (3) @(negedge ref_clk_i);
        chk(exp_q.size() == 0 && out_valid_o === 1'b0, "output not drained");
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ************************************************************
    // Output watcher
    // ************************************************************
    always @(posedge ref_clk_i) begin
        if (rst_n_i === 1'b1 && out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_fail++;
                $display("Error at %0t: unexpected output byte", $time);
            end else begin
                ex = exp_q.pop_front();
                tests_run++;
                if (((out_data_o ^ ex.d) & ex.m) !== 8'h00 || out_sop_o !== ex.s) begin
                    n_fail++;
                    $display("Error at %0t: byte %h expected %h", $time, out_data_o, ex.d);
                end
            end
        end
        if (frame_sync_o === 1'b1) begin
            fs_cnt++;
            tests_run++;
            if (pkt_num_o !== PKT_NUM_ZERO) begin
                n_fail++;
                $display("Error at %0t: frame pulse off packet zero", $time);
            end
        end
    end

    initial begin
        repeat (40000) @(posedge ref_clk_i);
        n_fail++;
        $display("Error at %0t: watchdog expired", $time);
        conclude();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        rst_n_i = 1'b0;
        mode_i = MODE_PASS;
        cfg_tier_i = 8'h00;
        cfg_offset_i = 16'h0000;
        side_bit_i = 1'b0;
        enhanced_i = 1'b0;
        in_data_i = 8'h00;
        in_sop_i = 1'b0;
        in_valid_i = 1'b0;
        hold = 1'b0;
        slow = 1'b1;
        rsv_val = 4'hA;
        lfsr_q = 32'h096b_40b0;
        n_fail = 0;
        tests_run = 0;
        fs_cnt = 0;
        repeat (8) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        chk(in_ready_o === 1'b1 && out_valid_o === 1'b0, "reset handshake state");
        chk(pkt_num_o === PKT_NUM_MAX && timing_word_o === 16'h0000, "reset counters");
        $display("test reset done");

        for (int k = 0; k < 2; k++) begin
            mode_i = (k == 0) ? MODE_PASS : 3'b011;
            send_pkt(SYNC_INV, 1'b1, NTP_PID, 8'h03, 10'h000, 16'h1357);
            drain();
        end
        $display("test pass done");

        mode_i = MODE_XLAT;
        cfg_tier_i = 8'h05;
        fs_cnt = 0;
        slow = 1'b0;
        send_pkt(SYNC_INV, 1'b1, 13'h0100, 8'h05, 10'h3FF, 16'hFFFF);
        send_pkt(SYNC_BYTE, 1'b1, NTP_PID, 8'h05, 10'h26E, 16'hA5C3);
        drain();
        chk(timing_word_o === 16'hA5C3, "timing word not loaded");
        send_pkt(SYNC_BYTE, 1'b0, 13'h0020, 8'h00, 10'h000, 16'h0000);
        drain();
        chk(pkt_num_o === PKT_NUM_MAX && fs_cnt == 0, "number before wrap");
        send_pkt(SYNC_BYTE, 1'b0, 13'h0020, 8'h00, 10'h000, 16'h0000);
        drain();
        chk(pkt_num_o === PKT_NUM_ZERO && fs_cnt == 1, "frame phase after wrap");
        send_pkt(SYNC_BYTE, 1'b0, NTP_PID, 8'h05, 10'h2BC, 16'hA5C3);
        send_pkt(SYNC_INV, 1'b1, NTP_PID, 8'h06, 10'h00A, 16'h1234);
        send_pkt(SYNC_BYTE, 1'b0, 13'h0020, 8'h00, 10'h000, 16'h0000);
        drain();
        chk(timing_word_o === 16'hA5C3, "foreign tier altered timing");
        chk(pkt_num_o === 10'h003 && fs_cnt == 1, "out of range number used");
        $display("test translator done");

        enhanced_i = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        chk(rsv_bits_o === RSV_DEFAULT, "reserved bits not default");
        enhanced_i = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        chk(rsv_bits_o === 4'hA, "reserved bits not forwarded");
        $display("test reserved done");

        hold = 1'b1;
        fork
            send_pkt(SYNC_BYTE, 1'b1, 13'h0040, 8'h00, 10'h000, 16'h0000);
            begin
                repeat (10) @(negedge ref_clk_i);
                chk(in_ready_o === 1'b0 && out_valid_o === 1'b1, "buffer not full");
                hold = 1'b0;
                slow = 1'b1;
            end
        join
        drain();
        $display("test buffer done");

        // Mid-run reset puts the counter on 623, so the first adapter packet is number 0
        rst_n_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        adp_pn = PKT_NUM_ZERO;
        chk(pkt_num_o === PKT_NUM_MAX && out_valid_o === 1'b0, "mid-run reset state");
        mode_i = MODE_ADAPT;
        cfg_tier_i = 8'h02;
        cfg_offset_i = 16'hBEEF;
        side_bit_i = 1'b1;
        slow = 1'b0;
        for (int k = 0; k < 5; k++) begin
            send_pkt(SYNC_BYTE, 1'b0, NTP_PID, (k < 4) ? k[7:0] : 8'h25, 10'h000, 16'h0000);
        end
        side_bit_i = 1'b0;
        send_pkt(SYNC_BYTE, 1'b1, 13'h0100, 8'h00, 10'h000, 16'h0000);
        drain();
        $display("test adapter done");
        conclude();
    end
endmodule

`default_nettype wire

// >>> ttp_core.sv
// Tiered translator packet processor: adapter, translator and pass modes
`timescale 1ns/1ps
`default_nettype none

module ttp_core
    import ttp_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [2:0] mode_i,
    input  wire logic [7:0] cfg_tier_i,
    input  wire logic [15:0] cfg_offset_i,
    input  wire logic       side_bit_i,
    input  wire logic       enhanced_i,
    input  wire logic [3:0] rsv_in_i,
    input  wire logic [7:0] in_data_i,
    input  wire logic       in_sop_i,
    input  wire logic       in_valid_i,
    output logic            in_ready_o,
    output logic [7:0]      out_data_o,
    output logic            out_sop_o,
    output logic            out_valid_o,
    input  wire logic       out_ready_i,
    output logic            frame_sync_o,
    output logic [15:0]     timing_word_o,
    output logic [9:0]      pkt_num_o,
    output logic [3:0]      rsv_bits_o
);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [9:0] pnum_next(input logic [9:0] n);
        return (n >= PKT_NUM_MAX) ? PKT_NUM_ZERO : n + 10'h001;
    endfunction

    function automatic logic [7:0] code_byte(input logic [7:0] acc,
                                             input logic [7:0] tier,
                                             input logic       second);
        return second ? (acc ^ tier) : acc;
    endfunction

    // ****************************************
    // Declarations
    // ****************************************
    ttp_mode_t   mode;
    ttp_state_t  state_ff;
    logic [7:0]  idx_ff;
    logic [7:0]  cur_idx;
    logic        take;
    logic        pkt_byte;
    logic [4:0]  pid_hi_ff;
    logic        is_ntp_ff;
    logic        hit_ff;
    logic        keep_ff;
    logic [7:0]  tier_ff;
    logic [1:0]  pnum_hi_ff;
    logic [9:0]  rx_pnum_ff;
    logic        load_ff;
    logic [7:0]  time_hi_ff;
    logic [7:0]  code_acc_ff;
    logic [9:0]  pkt_num_ff;
    logic [9:0]  nxt_pkt_num;
    logic [7:0]  nxt_byte;
    logic        fifo_ready;

    always_comb begin
        unique case (mode_i)
            MODE_ADAPT: mode = MODE_ADAPT;
            MODE_XLAT:  mode = MODE_XLAT;
            default:    mode = MODE_PASS;
        endcase
    end

    assign in_ready_o = fifo_ready;
    assign take       = in_valid_i && fifo_ready;
    assign cur_idx    = in_sop_i ? IDX_SYNC : idx_ff;
    assign pkt_byte   = in_sop_i || (state_ff == ST_PKT);
    assign pkt_num_o  = pkt_num_ff;

    // ****************************************
    // Packet framing
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_ff <= ST_HUNT;
            idx_ff   <= IDX_SYNC;
        end else if (take) begin
            unique case (state_ff)
                ST_HUNT: begin
                    if (in_sop_i) begin
                        state_ff <= ST_PKT;
                        idx_ff   <= IDX_PID_HI;
                    end
                end
                ST_PKT: begin
                    if (in_sop_i) begin
                        idx_ff <= IDX_PID_HI;
                    end else if (idx_ff == IDX_LAST) begin
                        state_ff <= ST_HUNT;
                    end else begin
                        idx_ff <= idx_ff + 8'h01;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Header and timing packet field capture
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pid_hi_ff <= '0;
            is_ntp_ff <= 1'b0;
        end else if (take && pkt_byte) begin
            if (cur_idx == IDX_SYNC) begin
                is_ntp_ff <= 1'b0;
            end
            if (cur_idx == IDX_PID_HI) begin
                pid_hi_ff <= in_data_i[4:0];
            end
            if (cur_idx == IDX_PID_LO) begin
                is_ntp_ff <= ({pid_hi_ff, in_data_i} == NTP_PID);
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            tier_ff <= '0;
            hit_ff  <= 1'b0;
            keep_ff <= 1'b0;
        end else if (take && pkt_byte) begin
            if (cur_idx == IDX_SYNC) begin
                hit_ff  <= 1'b0;
                keep_ff <= 1'b0;
            end
            if (cur_idx == IDX_TIER && is_ntp_ff) begin
                tier_ff <= in_data_i;
                hit_ff  <= (in_data_i == cfg_tier_i);
                keep_ff <= (in_data_i <= cfg_tier_i) && (in_data_i <= TIER_MAX);
            end
        end
    end

    // ****************************************
    // Translator timing recovery
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pnum_hi_ff    <= '0;
            rx_pnum_ff    <= PKT_NUM_ZERO;
            load_ff       <= 1'b0;
            time_hi_ff    <= '0;
            timing_word_o <= '0;
        end else if (take && pkt_byte) begin
            if (cur_idx == IDX_SYNC) begin
                load_ff <= 1'b0;
            end
            if (mode == MODE_XLAT && is_ntp_ff && hit_ff) begin
                if (cur_idx == IDX_PNUM_HI) begin
                    pnum_hi_ff <= in_data_i[1:0];
                end
                if (cur_idx == IDX_PNUM_LO && {pnum_hi_ff, in_data_i} <= PKT_NUM_MAX) begin
                    rx_pnum_ff <= {pnum_hi_ff, in_data_i};
                    load_ff    <= 1'b1;
                end
                if (cur_idx == IDX_TIME_HI) begin
                    time_hi_ff <= in_data_i;
                end
                if (cur_idx == IDX_TIME_LO) begin
                    timing_word_o <= {time_hi_ff, in_data_i};
                end
            end
        end
    end

    // Packet counter; a translator re-phases it from the addressed timing packet
    always_comb begin
        nxt_pkt_num = pnum_next(pkt_num_ff);
        if (mode == MODE_XLAT && load_ff) begin
            nxt_pkt_num = pnum_next(rx_pnum_ff);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pkt_num_ff   <= PKT_NUM_MAX;
            frame_sync_o <= 1'b0;
        end else begin
            frame_sync_o <= 1'b0;
            if (take && in_sop_i) begin
                pkt_num_ff   <= nxt_pkt_num;
                frame_sync_o <= (mode == MODE_XLAT) && (nxt_pkt_num == PKT_NUM_ZERO);
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rsv_bits_o <= RSV_DEFAULT;
        end else begin
            rsv_bits_o <= enhanced_i ? rsv_in_i : RSV_DEFAULT;
        end
    end

    // ****************************************
    // Adapter coding model accumulator
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            code_acc_ff <= '0;
        end else if (take && pkt_byte) begin
            if (cur_idx == IDX_SYNC) begin
                code_acc_ff <= '0;
            end else if (cur_idx >= IDX_TIER && cur_idx < IDX_CODE_A) begin
                code_acc_ff <= code_acc_ff ^ nxt_byte;
            end
        end
    end

    // ****************************************
    // Byte rewrite
    // ****************************************
    always_comb begin
        nxt_byte = in_data_i;
        if (pkt_byte) begin
            unique case (mode)
                MODE_ADAPT: begin
                    if (cur_idx == IDX_SYNC && nxt_pkt_num == PKT_NUM_ZERO) begin
                        nxt_byte = SYNC_INV;
                    end else if (cur_idx == IDX_PID_HI) begin
                        nxt_byte[TEF_BIT] = side_bit_i;
                    end else if (is_ntp_ff && cur_idx > IDX_TIER) begin
                        if (!keep_ff) begin
                            nxt_byte = BLANK_BYTE;
                        end else if (cur_idx == IDX_PNUM_HI) begin
                            nxt_byte = {6'h00, pkt_num_ff[9:8]};
                        end else if (cur_idx == IDX_PNUM_LO) begin
                            nxt_byte = pkt_num_ff[7:0];
                        end else if (cur_idx == IDX_TIME_HI) begin
                            nxt_byte = cfg_offset_i[15:8];
                        end else if (cur_idx == IDX_TIME_LO) begin
                            nxt_byte = cfg_offset_i[7:0];
                        end else if (cur_idx == IDX_CODE_A || cur_idx == IDX_CODE_B) begin
                            nxt_byte = code_byte(code_acc_ff, tier_ff, cur_idx == IDX_CODE_B);
                        end
                    end
                end
                MODE_XLAT: begin
                    if (cur_idx == IDX_SYNC) begin
                        nxt_byte = SYNC_BYTE;
                    end else if (cur_idx == IDX_PID_HI) begin
                        nxt_byte[TEF_BIT] = 1'b0;
                    end
                end
                MODE_PASS: begin
                    nxt_byte = in_data_i;
                end
            endcase
        end
    end

    ttp_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .rst_n_i     (rst_n_i),
        .in_data_i   ({in_sop_i, nxt_byte}),
        .in_valid_i  (in_valid_i),
        .in_ready_o  (fifo_ready),
        .out_data_o  ({out_sop_o, out_data_o}),
        .out_valid_o (out_valid_o),
        .out_ready_i (out_ready_i)
    );

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_tef_cleared: assert property (
        take && mode == MODE_XLAT && pkt_byte && cur_idx == IDX_PID_HI |-> !nxt_byte[TEF_BIT])
        else $error("header error flag not cleared");
    chk_pass_intact: assert property (
        take && mode == MODE_PASS |-> nxt_byte == in_data_i)
        else $error("pass mode altered a byte");
    chk_sync_invert: assert property (
        take && mode == MODE_ADAPT && in_sop_i && nxt_pkt_num == PKT_NUM_ZERO
        |-> nxt_byte == SYNC_INV)
        else $error("cadence sync not inverted");
    chk_sync_plain: assert property (
        take && mode == MODE_XLAT && in_sop_i |-> nxt_byte == SYNC_BYTE)
        else $error("translator emitted odd sync");
    chk_frame_phase: assert property (
        frame_sync_o |-> pkt_num_ff == PKT_NUM_ZERO && $past(take) && $past(in_sop_i))
        else $error("frame sync off phase");
    chk_pnum_range: assert property (pkt_num_ff <= PKT_NUM_MAX)
        else $error("packet number out of range");
    chk_forward_other: assert property (
        take && mode == MODE_XLAT && is_ntp_ff && !hit_ff && cur_idx > IDX_PID_HI
        |-> nxt_byte == in_data_i)
        else $error("foreign timing packet modified");
    chk_tier_match: assert property (
        take && pkt_byte && is_ntp_ff && cur_idx == IDX_TIER
        |=> hit_ff == ($past(in_data_i) == $past(cfg_tier_i)))
        else $error("tier compare wrong");
    chk_blank_restore: assert property (
        take && mode == MODE_ADAPT && is_ntp_ff && !keep_ff && !in_sop_i && cur_idx > IDX_TIER
        |-> nxt_byte == BLANK_BYTE)
        else $error("uncoded timing packet not blanked");
    chk_timing_load: assert property (
        take && mode == MODE_XLAT && is_ntp_ff && hit_ff && !in_sop_i && cur_idx == IDX_TIME_LO
        |=> timing_word_o[7:0] == $past(in_data_i))
        else $error("timing word not captured");
    chk_rsv_default: assert property (
        !enhanced_i |=> rsv_bits_o == RSV_DEFAULT)
        else $error("reserved bits not default");

    cov_frame_sync:  cover property (frame_sync_o);
    cov_adapt_code:  cover property (take && mode == MODE_ADAPT && keep_ff && cur_idx == IDX_CODE_B);
    cov_xlat_hit:    cover property (take && mode == MODE_XLAT && hit_ff && cur_idx == IDX_TIME_LO);
    cov_fifo_full:   cover property (in_valid_i && !fifo_ready);
endmodule

`default_nettype wire

// >>> ttp_fifo.sv
// Shared constants for the tiered translator packet logic, and its output FIFO
`timescale 1ns/1ps
`default_nettype none

package ttp_pkg;
    localparam logic [7:0] SYNC_BYTE    = 8'h47;
    localparam logic [7:0] SYNC_INV     = 8'hB8;
    localparam logic [7:0] BLANK_BYTE   = 8'hFF;
    localparam logic [12:0] NTP_PID     = 13'h1F_FB;
    localparam logic [7:0] TIER_MAX     = 8'h1F;
    localparam logic [9:0] PKT_NUM_MAX  = 10'h26F;
    localparam logic [9:0] PKT_NUM_ZERO = 10'h000;
    localparam logic [7:0] IDX_SYNC     = 8'h00;
    localparam logic [7:0] IDX_PID_HI   = 8'h01;
    localparam logic [7:0] IDX_PID_LO   = 8'h02;
    localparam logic [7:0] IDX_TIER     = 8'h04;
    localparam logic [7:0] IDX_PNUM_HI  = 8'h05;
    localparam logic [7:0] IDX_PNUM_LO  = 8'h06;
    localparam logic [7:0] IDX_TIME_HI  = 8'h07;
    localparam logic [7:0] IDX_TIME_LO  = 8'h08;
    localparam logic [7:0] IDX_CODE_A   = 8'h09;
    localparam logic [7:0] IDX_CODE_B   = 8'h0A;
    localparam logic [7:0] IDX_LAST     = 8'hBB;
    localparam int         TEF_BIT      = 7;
    localparam logic [3:0] RSV_DEFAULT  = 4'h0;
    localparam int         FIFO_DEPTH   = 4;
    localparam int         FIFO_WIDTH   = 9;
    typedef enum logic [2:0] {
        MODE_PASS  = 3'b001,
        MODE_ADAPT = 3'b010,
        MODE_XLAT  = 3'b100
    } ttp_mode_t;
    typedef enum logic [1:0] {
        ST_HUNT = 2'b01,
        ST_PKT  = 2'b10
    } ttp_state_t;
endpackage

module ttp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      cnt_ff;
    logic             push;
    logic             pop;

    assign in_ready_o  = (cnt_ff != CNT_FULL);
    assign out_valid_o = (cnt_ff != '0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem_ff[rd_ptr_ff];

    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff    <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == PTR_LAST) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == PTR_LAST) ? '0 : rd_ptr_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_fifo_bound: assert property (cnt_ff <= CNT_FULL)
        else $error("fifo count beyond depth");
endmodule

`default_nettype wire

// >>> ttp_sink_model.sv
// Downstream sink and reserved-bit receiver facing the packet processor
`timescale 1ns/1ps
`default_nettype none

module ttp_sink_model (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       hold_i,
    input  wire logic       slow_i,
    input  wire logic [3:0] rsv_val_i,
    output logic            out_ready_o,
    output logic [3:0]      rsv_o
);
    logic toggle_ff;

    // Ready moves only just after a falling edge, never near the sampling edge
    always_ff @(negedge ref_clk_i) begin
        if (!rst_n_i) begin
            toggle_ff <= 1'b0;
        end else begin
            toggle_ff <= ~toggle_ff;
        end
    end

    // Recovered reserved bits handed on to the translator
    always_ff @(negedge ref_clk_i) begin
        if (!rst_n_i) begin
            rsv_o <= 4'h0;
        end else begin
            rsv_o <= rsv_val_i;
        end
    end

    assign out_ready_o = !hold_i && (!slow_i || toggle_ff);
endmodule

`default_nettype wire
